//--- verilog/spsb_pkg.sv
/*
 * shared constants and types of the serial byte port: frame layout, setup codes,
 * status byte fields, controller register map, link timing and state encodings.
 * assumes a 100 MHz system clock on both ends.
 */
package spsb_pkg;

    // ==========================================================================
    // frame layout, counted in serial clock rising edges from the start bit
    // ==========================================================================
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned FRAME_CYCLES  = 13;
    localparam logic [3:0]  BIT_START     = 4'h0;
    localparam logic [3:0]  BIT_DIR       = 4'h1;
    localparam logic [3:0]  BIT_ADDR      = 4'h2;
    localparam logic [3:0]  BIT_FIRST_DAT = 4'h3;
    localparam logic [3:0]  BIT_LAST_DAT  = 4'hA;
    localparam logic [3:0]  BIT_STATUS    = 4'hB;
    localparam logic [3:0]  BIT_LAST      = 4'hC;

    // ==========================================================================
    // setup codes {direction, target address}
    // ==========================================================================
    localparam logic [1:0] OP_DATA_READ   = 2'h2;
    localparam logic [1:0] OP_STATUS_READ = 2'h3;
    localparam logic [1:0] OP_DATA_WRITE  = 2'h0;
    localparam logic [1:0] OP_UNDEFINED   = 2'h1;

    // status byte fields; other bits read zero
    localparam int unsigned STAT_RX_FULL    = 0;
    localparam int unsigned STAT_TX_EMPTY   = 1;
    localparam int unsigned STAT_RX_IRQ_EN  = 4;
    localparam int unsigned STAT_TX_IRQ_EN  = 5;

    // status bit values
    localparam logic STATUS_OK    = 1'b0;
    localparam logic STATUS_STALE = 1'b1;

    // ==========================================================================
    // controller registers, byte addresses of 32-bit words
    // ==========================================================================
    localparam int unsigned REG_ADDR_W = 4;
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_TXDATA = 4'h4;
    localparam logic [3:0]  REG_RXDATA = 4'h8;
    localparam logic [3:0]  REG_STATUS = 4'hC;
    localparam int unsigned CTRL_GO    = 2;
    localparam int unsigned CTRL_ABORT = 3;
    localparam int unsigned ST_BUSY    = 0;
    localparam int unsigned ST_DONE    = 1;
    localparam int unsigned ST_LASTBIT = 2;
    localparam int unsigned ST_RETRY   = 3;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    // ==========================================================================
    // timing
    // ==========================================================================
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned SCLK_MIN_PERIOD_NS = 83;
    localparam int unsigned SCLK_HALF_CYCLES   =
        (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

    // ==========================================================================
    // state encodings
    // ==========================================================================
    typedef enum logic [4:0] {
        DS_IDLE   = 5'h01,
        DS_SETUP  = 5'h02,
        DS_SHIFT  = 5'h04,
        DS_STATUS = 5'h08,
        DS_TAIL   = 5'h10
    } spsb_dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'h1,
        HS_RUN  = 3'h2,
        HS_GAP  = 3'h4
    } spsb_host_state_t;

endpackage : spsb_pkg

//--- verilog/spsb_link_if.sv
/*
 * four-wire link between the serial master and the byte port.
 * assumes the bench joins both modports; no wire here is two-way.
 */
interface spsb_link_if;
    logic sclk;
    logic cs;
    logic sdi;
    logic sdo;

    modport dev (input sclk, input cs, input sdi, output sdo);
    modport host (output sclk, output cs, output sdi, input sdo);
endinterface : spsb_link_if

//--- verilog/spsb_sync.sv
/*
 * two flip-flop synchroniser for a group of level signals.
 * assumes the inputs are asynchronous to clk and each bit may be taken alone.
 */
module spsb_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule : spsb_sync

//--- verilog/spsb_device.sv
/*
 * slave end of the serial byte port: decodes 13-edge frames, serves data reads
 * from the transmit buffer, data writes into the receive buffer, and status reads.
 * assumes the buffers sit on clk; the link pins are asynchronous and pass a
 * synchroniser, so the serial clock must stay well below a quarter of clk.
 */
// What this block does
// - slave only; master clocks, at most 12MHz
// - one byte per fixed 13-edge frame
// - master sends direction then address bit
// - 10 read, 11 status, 00 write, 01 unused
// - data bits travel most significant first
// - device drives status bit after each byte
// - all pins act on serial clock rise
// - chip select high, held through whole frame
// - data frames need select low one cycle
// - start on input and select high idle
// - frame ends after 13; next needs start
// - read shifts buffer byte out, then status
// - read status 0 pops, 1 means stale
// - master repeats stale reads until fresh
// - status valid until edge after last bit
// - write: status driven on next edge
// - write status 0 accepted, 1 rejected full
// - master resends rejected byte until accepted
// - master polls transmit buffer before commands; host sends commands without polling
// - status byte: full, empty, two enables
// - trailing bit after status byte is zero
// - status read valid only in its frame
module spsb_device (
    spsb_link_if.dev                        link,
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic [spsb_pkg::BYTE_W-1:0] txData,
    input  wire logic                       txValid,
    output logic                            txPop,
    output logic      [spsb_pkg::BYTE_W-1:0] rxData,
    output logic                            rxPush,
    input  wire logic                       rxFullFlag,
    input  wire logic                       rxFullIrqEnable,
    input  wire logic                       txEmptyIrqEnable,
    output logic      [3:0]                 frameEdge,
    output logic                            frameActive
);
    import spsb_pkg::*;

    // ==========================================================================
    // pin sampling
    // ==========================================================================
    logic [2:0]            pinSync;
    logic                  sclkS;
    logic                  csS;
    logic                  sdiS;
    logic                  sclkPrev;
    logic                  sclkRise;
    spsb_dev_state_t       state;
    logic [3:0]            bitCnt;
    logic                  dirBit;
    logic [1:0]            opCode;
    logic [BYTE_W-1:0]     shiftReg;
    logic                  freshByte;
    logic                  sdoReg;
    logic                  txEmptyFlag;
    logic [BYTE_W-1:0]     statusByte;
    logic                  lastDataRise;
    logic [BYTE_W-1:0]     writeByte;

    spsb_sync #(
        .WIDTH (3)
    ) uPinSync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({link.sclk, link.cs, link.sdi}),
        .dout   (pinSync)
    );

    assign sclkS = pinSync[2];
    assign csS   = pinSync[1];
    assign sdiS  = pinSync[0];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclkPrev <= 1'b0;
        end else begin
            sclkPrev <= sclkS;
        end
    end

    // pins are acted on only at the rising serial clock edge
    assign sclkRise = sclkS & ~sclkPrev;

    // ==========================================================================
    // status byte
    // ==========================================================================
    assign txEmptyFlag = ~txValid;

    always_comb begin
        statusByte                 = '0;
        statusByte[STAT_RX_FULL]   = rxFullFlag;
        statusByte[STAT_TX_EMPTY]  = txEmptyFlag;
        statusByte[STAT_RX_IRQ_EN] = rxFullIrqEnable;
        statusByte[STAT_TX_IRQ_EN] = txEmptyIrqEnable;
    end

    assign lastDataRise = sclkRise && csS && (state == DS_SHIFT) && (bitCnt == BIT_LAST_DAT);
    assign writeByte    = {shiftReg[BYTE_W-2:0], sdiS};

    // ==========================================================================
    // frame sequencer
    // ==========================================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state  <= DS_IDLE;
            bitCnt <= BIT_START;
        end else if (sclkRise) begin
            if ((state != DS_IDLE) && !csS) begin
                // select dropped mid-frame: give up the frame
                state  <= DS_IDLE;
                bitCnt <= BIT_START;
            end else begin
                case (state)
                    DS_IDLE: begin
                        if (csS && sdiS) begin
                            state  <= DS_SETUP;
                            bitCnt <= BIT_DIR;
                        end
                    end
                    DS_SETUP: begin
                        bitCnt <= 4'(bitCnt + 4'h1);
                        if (bitCnt == BIT_ADDR) begin
                            state <= DS_SHIFT;
                        end
                    end
                    DS_SHIFT: begin
                        bitCnt <= 4'(bitCnt + 4'h1);
                        if (bitCnt == BIT_LAST_DAT) begin
                            state <= DS_STATUS;
                        end
                    end
                    DS_STATUS: begin
                        bitCnt <= BIT_LAST;
                        state  <= DS_TAIL;
                    end
                    DS_TAIL: begin
                        // thirteenth edge; a new start is needed after it
                        state  <= DS_IDLE;
                        bitCnt <= BIT_START;
                    end
                    default: begin
                        state  <= DS_IDLE;
                        bitCnt <= BIT_START;
                    end
                endcase
            end
        end
    end

    // ==========================================================================
    // shifter and serial output
    // ==========================================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dirBit    <= 1'b0;
            opCode    <= OP_DATA_WRITE;
            shiftReg  <= '0;
            freshByte <= 1'b0;
            sdoReg    <= 1'b0;
        end else if (sclkRise) begin
            if ((state != DS_IDLE) && !csS) begin
                sdoReg <= 1'b0;
            end else if ((state == DS_SETUP) && (bitCnt == BIT_DIR)) begin
                dirBit <= sdiS;
            end else if ((state == DS_SETUP) && (bitCnt == BIT_ADDR)) begin
                opCode <= {dirBit, sdiS};
                if ({dirBit, sdiS} == OP_DATA_READ) begin
                    shiftReg  <= txData;
                    freshByte <= txValid;
                    sdoReg    <= txData[BYTE_W-1];
                end else if ({dirBit, sdiS} == OP_STATUS_READ) begin
                    shiftReg  <= statusByte;
                    freshByte <= 1'b0;
                    sdoReg    <= statusByte[BYTE_W-1];
                end else begin
                    shiftReg  <= '0;
                    freshByte <= 1'b0;
                    sdoReg    <= 1'b0;
                end
            end else if (state == DS_SHIFT) begin
                if (bitCnt == BIT_LAST_DAT) begin
                    if (opCode == OP_DATA_READ) begin
                        sdoReg <= freshByte ? STATUS_OK : STATUS_STALE;
                    end else if (opCode == OP_DATA_WRITE) begin
                        sdoReg <= rxFullFlag ? STATUS_STALE : STATUS_OK;
                    end else begin
                        sdoReg <= STATUS_OK;
                    end
                end else if (opCode == OP_DATA_WRITE) begin
                    shiftReg <= writeByte;
                end else if (opCode[1]) begin
                    shiftReg <= {shiftReg[BYTE_W-2:0], 1'b0};
                    sdoReg   <= shiftReg[BYTE_W-2];
                end
            end else begin
                // status bit holds only until the edge after the last data bit
                sdoReg <= 1'b0;
            end
        end
    end

    assign link.sdo = sdoReg;

    // ==========================================================================
    // buffer handshakes
    // ==========================================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            txPop  <= 1'b0;
            rxPush <= 1'b0;
            rxData <= '0;
        end else begin
            txPop  <= lastDataRise && (opCode == OP_DATA_READ) && freshByte;
            rxPush <= lastDataRise && (opCode == OP_DATA_WRITE) && !rxFullFlag;
            if (lastDataRise && (opCode == OP_DATA_WRITE) && !rxFullFlag) begin
                rxData <= writeByte;
            end
        end
    end

    // ==========================================================================
    // frame observation
    // ==========================================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            frameEdge   <= BIT_START;
            frameActive <= 1'b0;
        end else begin
            frameEdge   <= bitCnt;
            frameActive <= (state != DS_IDLE);
        end
    end

endmodule : spsb_device

//--- verilog/spsb_host.sv
/*
 * master end of the serial byte port, commanded through four word registers.
 * runs whole 13-edge frames, retries stale reads and rejected writes, and keeps
 * select low for one serial clock after every frame.
 * assumes the device samples on the rising edge; sdo comes in asynchronously.
 */
module spsb_host #(
    parameter int unsigned SCLK_HALF = spsb_pkg::SCLK_HALF_CYCLES
) (
    spsb_link_if.host                           link,
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire logic [spsb_pkg::REG_ADDR_W-1:0] regAddr,
    input  wire logic [31:0]                    regWdata,
    input  wire logic                           regWr,
    input  wire logic                           regRd,
    output logic      [31:0]                    regRdata
);
    import spsb_pkg::*;

    spsb_host_state_t  state;
    logic [7:0]        halfCnt;
    logic              sclkOut;
    logic              csOut;
    logic              sdiOut;
    logic [3:0]        bitIdx;
    logic [1:0]        opReg;
    logic [BYTE_W-1:0] txByte;
    logic [BYTE_W-1:0] rxByte;
    logic [BYTE_W-1:0] rxShift;
    logic              lastStatus;
    logic              doneFlag;
    logic              retryOn;
    logic              sdoS;
    logic              tick;
    logic              riseTick;
    logic              fallTick;
    logic              goReq;
    logic              needRetry;
    logic              frameEnd;

    // bit presented on sdi ahead of each rising edge
    function automatic logic frameBit(input logic [3:0] idx, input logic [1:0] op,
                                      input logic [BYTE_W-1:0] data);
        logic b;
        b = 1'b0;
        if (idx == BIT_START) begin
            b = 1'b1;
        end else if (idx == BIT_DIR) begin
            b = op[1];
        end else if (idx == BIT_ADDR) begin
            b = op[0];
        end else if ((idx <= BIT_LAST_DAT) && (op == OP_DATA_WRITE)) begin
            b = data[3'(BIT_LAST_DAT - idx)];
        end
        return b;
    endfunction : frameBit

    spsb_sync #(
        .WIDTH (1)
    ) uSdoSync (
        .clk    (clk),
        .resetn (resetn),
        .din    (link.sdo),
        .dout   (sdoS)
    );

    // ==========================================================================
    // serial clock divider and sequencing
    // ==========================================================================
    assign tick      = (state != HS_IDLE) && (halfCnt == 8'(SCLK_HALF - 1));
    assign riseTick  = tick && !sclkOut;
    assign fallTick  = tick && sclkOut;
    assign frameEnd  = fallTick && (state == HS_GAP);
    assign goReq     = regWr && (regAddr == REG_CTRL) && regWdata[CTRL_GO]
                       && (state == HS_IDLE) && (regWdata[1:0] != OP_UNDEFINED);
    assign needRetry = retryOn && (lastStatus == STATUS_STALE)
                       && (opReg != OP_STATUS_READ);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state   <= HS_IDLE;
            halfCnt <= 8'h00;
            sclkOut <= 1'b0;
            csOut   <= 1'b0;
            sdiOut  <= 1'b0;
            bitIdx  <= BIT_START;
        end else if (state == HS_IDLE) begin
            if (goReq) begin
                state   <= HS_RUN;
                halfCnt <= 8'h00;
                csOut   <= 1'b1;
                sdiOut  <= 1'b1;
                bitIdx  <= BIT_START;
            end
        end else if (!tick) begin
            halfCnt <= 8'(halfCnt + 8'h01);
        end else begin
            halfCnt <= 8'h00;
            sclkOut <= ~sclkOut;
            if (sclkOut && (state == HS_RUN)) begin
                if (bitIdx == BIT_LAST) begin
                    state  <= HS_GAP;
                    csOut  <= 1'b0;
                    sdiOut <= 1'b0;
                end else begin
                    bitIdx <= 4'(bitIdx + 4'h1);
                    sdiOut <= frameBit(4'(bitIdx + 4'h1), opReg, txByte);
                end
            end else if (sclkOut) begin
                if (needRetry) begin
                    state  <= HS_RUN;
                    csOut  <= 1'b1;
                    sdiOut <= 1'b1;
                    bitIdx <= BIT_START;
                end else begin
                    state <= HS_IDLE;
                end
            end
        end
    end

    assign link.sclk = sclkOut;
    assign link.cs   = csOut;
    assign link.sdi  = sdiOut;

    // ==========================================================================
    // sampling of sdo at rising edges
    // ==========================================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxShift    <= '0;
            lastStatus <= 1'b0;
        end else if (riseTick && (state == HS_RUN)) begin
            if ((bitIdx >= BIT_FIRST_DAT) && (bitIdx <= BIT_LAST_DAT)) begin
                rxShift <= {rxShift[BYTE_W-2:0], sdoS};
            end else if (bitIdx == BIT_STATUS) begin
                lastStatus <= sdoS;
            end
        end
    end

    // ==========================================================================
    // registers
    // ==========================================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            opReg    <= OP_DATA_READ;
            txByte   <= '0;
            rxByte   <= '0;
            doneFlag <= 1'b0;
            retryOn  <= 1'b0;
        end else begin
            if (goReq) begin
                opReg    <= regWdata[1:0];
                doneFlag <= 1'b0;
                retryOn  <= 1'b1;
            end else if (regWr && (regAddr == REG_CTRL) && regWdata[CTRL_ABORT]) begin
                retryOn <= 1'b0;
            end
            if (regWr && (regAddr == REG_TXDATA) && (state == HS_IDLE)) begin
                txByte <= regWdata[BYTE_W-1:0];
            end
            if (frameEnd && !needRetry) begin
                doneFlag <= 1'b1;
                rxByte   <= rxShift;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            regRdata <= WORD_ZERO;
        end else if (!regRd) begin
            regRdata <= WORD_ZERO;
        end else if (regAddr == REG_CTRL) begin
            regRdata <= {30'h0000_0000, opReg};
        end else if (regAddr == REG_TXDATA) begin
            regRdata <= {24'h00_0000, txByte};
        end else if (regAddr == REG_RXDATA) begin
            regRdata <= {24'h00_0000, rxByte};
        end else if (regAddr == REG_STATUS) begin
            regRdata <= {28'h000_0000, retryOn, lastStatus, doneFlag, state != HS_IDLE};
        end else begin
            regRdata <= WORD_ZERO;
        end
    end

endmodule : spsb_host

//--- tb/spsb_link_sva.sv
/* link checker of the serial byte port.
   assumes the host's default divider, ten clk per serial clock. */
module spsb_link_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs,
    input wire logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] nRise;
    logic [1:0] setupBits;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk) begin
        if (!resetn || !cs) nRise <= 4'h0;
        else if ($rose(sclk)) nRise <= nRise + 4'h1;
    end
    // direction and address bits of the current frame
    always_ff @(posedge clk) begin
        if (!resetn) setupBits <= 2'h0;
        else if ($rose(sclk) && cs && (nRise == 4'h1 || nRise == 4'h2))
            setupBits <= {setupBits[0], sdi};
    end
    AST_LEN: assert property ($fell(cs) |-> nRise == 4'hD) else $error("bad length");
    AST_START: assert property ($rose(sclk) && cs && nRise == 4'h0 |-> sdi)
        else $error("no start bit");
    AST_GAP: assert property ($fell(cs) |-> !cs [*8]) else $error("short gap");
    AST_IDLE: assert property (!cs [*8] |-> !sdo) else $error("idle output");
    AST_TRAIL: assert property ($rose(sclk) && nRise == 4'hB && &setupBits |-> !sdo)
        else $error("trail not low");
    AST_SDO: assert property ($rose(sclk) |-> $stable(sdo) ##1 $stable(sdo))
        else $error("output moved");
    AST_SDI: assert property (sclk |-> $stable(sdi) && $stable(cs))
        else $error("input moved");
    AST_HIGH: assert property ($rose(sclk) |-> sclk [*5]) else $error("short high");
    cover property ($fell(cs) && nRise == 4'hD);
    cover property ($rose(sclk) && nRise == 4'hB && sdo);
    cover property ($rose(sclk) && nRise == 4'hB && !sdo);
endmodule : spsb_link_sva

//--- tb/tb.sv
/* bench of the serial byte port: host and device joined by the link.
   assumes the host's default divider and a 100 MHz clk. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spsb_pkg::*;
    logic        clk = 1'h0, resetn = 1'h0, regWr = 1'h0, regRd = 1'h0, txPop, rxPush;
    logic        txValid = 1'h0, rxFullFlag = 1'h0;
    logic [1:0]  irqEn = 2'h0;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  txData = 8'h00, rxData;
    logic [31:0] regWdata = 32'h0000_0000, regRdata, v;
    int          errCount = 0, nTests = 0, nPop = 0, nPush = 0, cyc = 0;
    logic [3:0]  frameEdge, edgePrev = 4'h0;
    logic        frameActive, actPrev = 1'h0;
    int          nFrame = 0, f0 = 0;
    spsb_link_if link ();
    spsb_device spsb_device_i (.link(link.dev), .clk, .resetn, .txData, .txValid, .txPop,
        .rxData, .rxPush, .rxFullFlag, .rxFullIrqEnable(irqEn[0]),
        .txEmptyIrqEnable(irqEn[1]), .frameEdge, .frameActive);
    spsb_host spsb_host_i (.link(link.host), .clk, .resetn, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata);
    spsb_link_sva spsb_link_sva_i (.clk, .resetn, .sclk(link.sclk), .cs(link.cs),
        .sdi(link.sdi), .sdo(link.sdo));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (txPop === 1'h1) nPop <= nPop + 1;
        if (rxPush === 1'h1) nPush <= nPush + 1;
        actPrev <= frameActive;
        edgePrev <= frameEdge;
        if (frameActive === 1'h1 && actPrev === 1'h0) nFrame <= nFrame + 1;
        if (frameActive === 1'h0 && actPrev === 1'h1)
            chk({28'h000_0000, edgePrev}, {28'h000_0000, BIT_LAST});
        if (cyc == 20000) begin
            errCount++;
            wrapUp();
        end
    end
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= w;
        regRd <= !w;
        @(posedge clk);
        regWr <= 1'h0;
        regRd <= 1'h0;
        @(posedge clk);
        v = regRdata;
    endtask : acc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one command, retries cut short by abort when asked; leaves status bits 2..0 in v
    task automatic run(input logic [1:0] op, input logic stop);
        acc(1'h1, REG_CTRL, {29'h000_0000, 1'h1, op});
        if (stop) begin
            repeat (400) @(posedge clk);
            acc(1'h1, REG_CTRL, {28'h000_0000, 2'h2, op});
        end
        v = 32'h0000_0001;
        for (int i = 0; i < 300 && v[ST_BUSY] !== 1'h0; i++) acc(1'h0, REG_STATUS, 32'h0);
        v = v & 32'h0000_0007;
    endtask : run
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrapUp
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        acc(1'h1, REG_TXDATA, 32'h0000_00A5);
        run(OP_DATA_WRITE, 1'h0);
        chk(v, 32'h0000_0002);
        chk({24'h00_0000, rxData}, 32'h0000_00A5);
        chk(nPush, 1);
        rxFullFlag <= 1'h1;
        f0 = nFrame;
        run(OP_DATA_WRITE, 1'h1);
        chk(v, 32'h0000_0006);
        chk(nPush, 1);
        chk(nFrame - f0 > 2, 1);
        txData <= 8'hC3;
        txValid <= 1'h1;
        run(OP_DATA_READ, 1'h0);
        chk(v, 32'h0000_0002);
        chk(nPop, 1);
        acc(1'h0, REG_RXDATA, 32'h0);
        chk(v, 32'h0000_00C3);
        txValid <= 1'h0;
        f0 = nFrame;
        run(OP_DATA_READ, 1'h1);
        chk(v, 32'h0000_0006);
        chk(nPop, 1);
        chk(nFrame - f0 > 2, 1);
        for (int k = 0; k < 16; k += 3) begin
            {irqEn, txValid, rxFullFlag} <= k[3:0];
            run(OP_STATUS_READ, 1'h0);
            chk(v, 32'h0000_0002);
            acc(1'h0, REG_RXDATA, 32'h0);
            chk(v, {26'h000_0000, irqEn, 2'h0, ~txValid, rxFullFlag});
        end
        // undefined setup code must be refused: no frame, op unchanged
        acc(1'h1, REG_CTRL, 32'h0000_0005);
        acc(1'h0, REG_STATUS, 32'h0);
        chk(v & 32'h0000_0001, 32'h0000_0000);
        acc(1'h0, REG_CTRL, 32'h0);
        chk(v, {30'h0000_0000, OP_STATUS_READ});
        wrapUp();
    end
endmodule : tb
